//--- rtl/lin_brk_defs.vh
// constants for the LIN break detector: register map, field layout, timing
// assumes inclusion by bare name from every design file that needs them
`ifndef LIN_BRK_DEFS_VH
`define LIN_BRK_DEFS_VH

// clock rates in Hz
`define SYS_CLK_HZ        50000000
`define LP_OSC_HZ         131000
`define SYNC_CLK_HZ       5000000
// tick divisors derived from the rates, whole system clocks per tick
`define LP_DIV            ((`SYS_CLK_HZ) / (`LP_OSC_HZ))
`define SYNC_DIV          ((`SYS_CLK_HZ) / (`SYNC_CLK_HZ))
`define DIV_W             9

// register byte addresses
`define ADDR_SYNC_TIMER   32'hffff_0788
`define ADDR_BRK_TIMER    32'hffff_0790
`define ADDR_STATUS       32'hffff_0794
`define ADDR_IRQ_CLEAR    32'hffff_0798
`define ADDR_IRQ_ENABLE   32'hffff_079c
`define ADDR_CONTROL      32'hffff_07a0

// widths and reset values
`define BRK_W             12
`define SYNC_W            16
`define BRK_CMP_RST       12'h047
`define BRK_CNT_MAX       12'hfff
`define FLAG_W            8
`define FLAG_RST          8'h00

// status / enable / clear field positions
`define FLAG_BREAK        0
`define FLAG_SYNC_DONE    1
`define FLAG_BRK_ERR      4
`define FLAG_MASK         8'h13
// control field position and reset value
`define CTRL_LIN_EN       0
`define CTRL_RST          1'h1

// sync field: timer runs from first falling edge to fifth
`define SYNC_EDGE_W       3
`define SYNC_EDGES        3'h4

`endif

//--- rtl/lin_pin_sync.v
// two-flop synchronizer for the LIN receive pin with edge pulses
// assumes the pin is asynchronous to sys_clk_i and idles high
`timescale 1ns/10ps
module lin_pin_sync (
   // clock and reset
   input  wire sys_clk_i,
   input  wire reset_n_i,
   // raw pin
   input  wire pin_i,
   // synchronized level and edges
   output reg  level_o,
   output wire fall_o,
   output wire rise_o
);
   reg meta;
   reg prev;

   // first flop feeds only the second; edges look at second and third
   always @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         meta    <= 1'b1;
         level_o <= 1'b1;
         prev    <= 1'b1;
      end else begin
         meta    <= pin_i;
         level_o <= meta;
         prev    <= level_o;
      end
   end

   assign fall_o = prev & ~level_o;
   assign rise_o = ~prev & level_o;
endmodule // lin_pin_sync

//--- rtl/lin_tick_gen.v
// divider making a one-cycle tick every DIV system clocks
// stands in for a slower oscillator so the block keeps one clock domain
`timescale 1ns/10ps
`include "lin_brk_defs.vh"
module lin_tick_gen #(
   parameter [`DIV_W-1:0] DIV = 9'h00a
) (
   // clock and reset
   input  wire sys_clk_i,
   input  wire reset_n_i,
   // tick out
   output reg  tick_o
);
   reg [`DIV_W-1:0] cnt;

   // free-running count, tick on wrap
   always @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         cnt    <= {`DIV_W{1'b0}};
         tick_o <= 1'b0;
      end else if (cnt == DIV - 9'h001) begin
         cnt    <= {`DIV_W{1'b0}};
         tick_o <= 1'b1;
      end else begin
         cnt    <= cnt + 9'h001;
         tick_o <= 1'b0;
      end
   end
endmodule // lin_tick_gen

//--- rtl/lin_break_detector.v
// LIN slave break-field detector with sync-field timer and interrupt flags
// assumes a plain register port on sys_clk_i and an asynchronous LIN rx pin
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/10ps
`include "lin_brk_defs.vh"
module lin_break_detector (
   // clock and reset
   input  wire                 sys_clk_i,
   input  wire                 reset_n_i,
   // register port
   input  wire [31:0]          addr_i,
   input  wire [31:0]          wr_data_i,
   input  wire                 wr_i,
   input  wire                 rd_i,
   output reg  [31:0]          rd_data_o,
   // LIN receive pin
   input  wire                 lin_rx_i,
   // interrupt and status
   output reg                  irq_o,
   output reg                  lin_low_o
);

   // decode helper used by both read and write paths
   function hit;
      input [31:0] a;
      input [31:0] ref_addr;
      begin
         hit = (a == ref_addr);
      end
   endfunction

   // synchronized pin and the two tick rates
   wire                  lin_level;
   wire                  lin_fall;
   wire                  lin_rise;
   wire                  lp_tick;
   wire                  sync_tick;

   // break timing state, one low pulse at a time
   reg  [`BRK_W-1:0]     brk_cnt;
   reg  [`BRK_W-1:0]     brk_cmp;
   reg                   brk_fired;
   reg                   brk_err_seen;
   reg                   low_run;
   // sync-field timing state
   reg                   sync_armed;
   reg                   sync_run;
   reg  [`SYNC_EDGE_W-1:0] sync_edges;
   reg  [`SYNC_W-1:0]    sync_cnt;
   // software visible registers
   reg  [`FLAG_W-1:0]    status;
   reg  [`FLAG_W-1:0]    irq_en;
   reg                   lin_en;

   // combinational next values
   reg  [`FLAG_W-1:0]    flag_set;
   reg  [`FLAG_W-1:0]    flag_clr;
   reg  [`FLAG_W-1:0]    next_status;
   reg  [`FLAG_W-1:0]    next_irq_en;
   reg  [`BRK_W-1:0]     next_brk_cnt;
   reg  [31:0]           next_rd_data;

   // register map, one 32-bit word each, narrow fields in the low bits
   //   sync timer   read only, count of 5 MHz ticks across the sync byte
   //   break timer  read returns and clears the count, write loads compare
   //   status       read only, sticky event flags
   //   irq clear    write only, a one clears the matching status bit
   //   irq enable   read and write, same layout as status
   //   control      read and write, bit 0 turns LIN mode on
   //   status bits: 0 break seen, 1 sync done, 4 bus stuck low
   //   all other addresses read zero and ignore writes

   // limits a user should know:
   //   both tick rates are divided down from sys_clk_i, so their accuracy
   //   is that of an integer divisor rather than a real oscillator
   //   the stuck-low error needs a full 4096 ticks of bus low
   //   the sync stop is fixed at the fifth falling edge of the sync byte
   //   timer read and compare write share one address, so the compare
   //   cannot be read back
   //   a timer read clears the count but does not end the pulse

   // one decoded strobe per register action
   wire rd_brk  = rd_i & hit(addr_i, `ADDR_BRK_TIMER);
   wire wr_brk  = wr_i & hit(addr_i, `ADDR_BRK_TIMER);
   wire wr_clr  = wr_i & hit(addr_i, `ADDR_IRQ_CLEAR);
   wire wr_en   = wr_i & hit(addr_i, `ADDR_IRQ_ENABLE);
   wire wr_ctrl = wr_i & hit(addr_i, `ADDR_CONTROL);

   // one low-power tick while a low pulse is being timed
   wire brk_step  = lin_en && low_run && lp_tick && !brk_err_seen;
   // fifth falling edge of the sync byte ends the measurement
   wire sync_stop = sync_run && lin_fall && (sync_edges == `SYNC_EDGES);

   // pin crosses into sys_clk_i before any logic looks at it
   lin_pin_sync u_pin (
      .sys_clk_i (sys_clk_i),
      .reset_n_i (reset_n_i),
      .pin_i     (lin_rx_i),
      .level_o   (lin_level),
      .fall_o    (lin_fall),
      .rise_o    (lin_rise)
   );

   // divisors as full integers, cut to the divider width on purpose
   localparam [31:0] LP_DIV_FULL   = `LP_DIV;
   localparam [31:0] SYNC_DIV_FULL = `SYNC_DIV;
   // the edge that starts the sync timer is the first of the five counted
   localparam [`SYNC_EDGE_W-1:0] SYNC_FIRST = {{(`SYNC_EDGE_W-1){1'b0}}, 1'b1};

   // low-power oscillator rate for the break timer
   lin_tick_gen #(
      .DIV (LP_DIV_FULL[`DIV_W-1:0])
   ) u_lp_tick (
      .sys_clk_i (sys_clk_i),
      .reset_n_i (reset_n_i),
      .tick_o    (lp_tick)
   );

   // 5 MHz rate for the sync-field timer, independent of baud rate
   lin_tick_gen #(
      .DIV (SYNC_DIV_FULL[`DIV_W-1:0])
   ) u_sync_tick (
      .sys_clk_i (sys_clk_i),
      .reset_n_i (reset_n_i),
      .tick_o    (sync_tick)
   );

   // break timer next value and hardware flag events
   always @* begin
      next_brk_cnt = brk_cnt;
      flag_set     = `FLAG_RST;
      // clear wins over a tick, so a read never leaves a stale count
      if (lin_fall || rd_brk) begin
         next_brk_cnt = {`BRK_W{1'b0}};
      end else if (brk_step) begin
         next_brk_cnt = brk_cnt + 12'h001;
      end
      // compare on every count; a read clear does not end the pulse
      if (brk_step && !lin_fall) begin
         if (brk_cnt + 12'h001 == brk_cmp && !brk_fired) begin
            flag_set[`FLAG_BREAK] = 1'b1;
         end
         if (brk_cnt == `BRK_CNT_MAX) begin
            flag_set[`FLAG_BRK_ERR] = 1'b1;
         end
      end
      if (sync_stop) begin
         flag_set[`FLAG_SYNC_DONE] = 1'b1;
      end
   end

   // sticky status: a set in the clearing cycle wins
   always @* begin
      flag_clr    = wr_clr ? wr_data_i[`FLAG_W-1:0] : `FLAG_RST;
      next_status = ((status & ~flag_clr) | flag_set) & `FLAG_MASK;
   end

   // enable value after this edge, so a mask write takes hold at once
   always @* begin
      next_irq_en = irq_en;
      if (wr_en) begin
         next_irq_en = wr_data_i[`FLAG_W-1:0] & `FLAG_MASK;
      end
   end

   // break timer, per-pulse state and the low-pulse tracker
   // the write path never touches the count, only the compare
   always @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         brk_cnt      <= {`BRK_W{1'b0}};
         brk_fired    <= 1'b0;
         brk_err_seen <= 1'b0;
         low_run      <= 1'b0;
      end else begin
         brk_cnt <= next_brk_cnt;
         if (lin_fall) begin
            // a new falling edge restarts detection, even mid-byte
            low_run      <= lin_en;
            brk_fired    <= 1'b0;
            brk_err_seen <= 1'b0;
         end else begin
            if (lin_rise) begin
               low_run <= 1'b0;
            end
            if (flag_set[`FLAG_BREAK]) begin
               brk_fired <= 1'b1;
            end
            if (flag_set[`FLAG_BRK_ERR]) begin
               brk_err_seen <= 1'b1;    // count wraps to zero and stops, bus stuck low
            end
         end
      end
   end

   // compare register only moves on a write or reset
   always @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         brk_cmp <= `BRK_CMP_RST;
      end else if (wr_brk) begin
         brk_cmp <= wr_data_i[`BRK_W-1:0];
      end
   end

   // sync-field timing, armed only by a valid break ending high
   // a pulse that ended in the stuck-low error never arms it
   always @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         sync_armed <= 1'b0;
         sync_run   <= 1'b0;
         sync_edges <= {`SYNC_EDGE_W{1'b0}};
         sync_cnt   <= {`SYNC_W{1'b0}};
      end else begin
         if (lin_rise && brk_fired && !brk_err_seen) begin
            sync_armed <= 1'b1;
            sync_run   <= 1'b0;
            sync_edges <= {`SYNC_EDGE_W{1'b0}};
         end else if (lin_fall && sync_armed) begin
            // first edge of the sync byte starts the timer and is counted
            sync_armed <= 1'b0;
            sync_run   <= 1'b1;
            sync_edges <= SYNC_FIRST;
            sync_cnt   <= {`SYNC_W{1'b0}};
         end else if (sync_run) begin
            if (lin_fall) begin
               if (sync_edges == `SYNC_EDGES) begin
                  sync_run <= 1'b0;     // count holds for software
               end else begin
                  sync_edges <= sync_edges + 3'h1;
               end
            end
            if (sync_tick && !sync_stop) begin
               sync_cnt <= sync_cnt + 16'h0001;
            end
         end
      end
   end

   // readback mux, answer in the cycle after the strobe
   // full address compare, so near misses read zero rather than alias
   always @* begin
      next_rd_data = 32'h0000_0000;
      if (hit(addr_i, `ADDR_BRK_TIMER)) begin
         next_rd_data[`BRK_W-1:0] = brk_cnt;
      end else if (hit(addr_i, `ADDR_SYNC_TIMER)) begin
         next_rd_data[`SYNC_W-1:0] = sync_cnt;
      end else if (hit(addr_i, `ADDR_STATUS)) begin
         next_rd_data[`FLAG_W-1:0] = status;
      end else if (hit(addr_i, `ADDR_IRQ_ENABLE)) begin
         next_rd_data[`FLAG_W-1:0] = irq_en;
      end else if (hit(addr_i, `ADDR_CONTROL)) begin
         next_rd_data[`CTRL_LIN_EN] = lin_en;
      end
   end

   // software registers and sticky flags
   always @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         status <= `FLAG_RST;
         irq_en <= `FLAG_RST;
         lin_en <= `CTRL_RST;
      end else begin
         status <= next_status;
         irq_en <= next_irq_en;
         if (wr_ctrl) begin
            lin_en <= wr_data_i[`CTRL_LIN_EN];
         end
      end
   end

   // top-level outputs, each straight from its own flop
   always @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         rd_data_o <= 32'h0000_0000;
         irq_o     <= 1'b0;
         lin_low_o <= 1'b0;
      end else begin
         // unmapped or write-only addresses read as zero
         rd_data_o <= rd_i ? next_rd_data : 32'h0000_0000;
         // next status and next enable, so irq_o tracks both with no lag
         irq_o     <= |(next_status & next_irq_en);
         // diagnostic copy of the bus level, high while the bus is low
         lin_low_o <= ~lin_level;
      end
   end

endmodule // lin_break_detector

//--- tb/lin_brk_checker.sv
// port assertions for the break detector
// assumes the defines header and the single sys_clk_i domain
`timescale 1ns/10ps
`include "lin_brk_defs.vh"
module lin_brk_checker (
   // clock and reset
   input wire        sys_clk_i,
   input wire        reset_n_i,
   // register port
   input wire [31:0] addr_i,
   input wire [31:0] wr_data_i,
   input wire        wr_i,
   input wire        rd_i,
   input wire [31:0] rd_data_o,
   // bus and status
   input wire        lin_rx_i,
   input wire        irq_o,
   input wire        lin_low_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!reset_n_i);
   // decoded accesses, shared by the properties
   wire rd_tmr = rd_i && addr_i == `ADDR_BRK_TIMER;
   wire rd_sta = rd_i && addr_i == `ADDR_STATUS;
   wire en_off = wr_i && addr_i == `ADDR_IRQ_ENABLE && wr_data_i[7:0] == 8'h00;
   wire mapped = addr_i == `ADDR_BRK_TIMER || addr_i == `ADDR_STATUS || addr_i == `ADDR_SYNC_TIMER
                 || addr_i == `ADDR_IRQ_ENABLE || addr_i == `ADDR_CONTROL;
   // read data only in the cycle after a strobe
   property p_rd_idle; !rd_i |=> rd_data_o == 32'h0000_0000; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside read");
   property p_unmapped; rd_i && !mapped |=> rd_data_o == 32'h0000_0000; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_tmr_width; rd_tmr |=> rd_data_o[31:12] == 20'h0_0000; endproperty
   a_tmr_width: assert property (p_tmr_width) else $error("timer wider than 12 bits");
   // a read clears, so a read right after sees at most one tick
   property p_tmr_clear; rd_tmr ##1 rd_tmr |=> rd_data_o[11:0] <= 12'h001; endproperty
   a_tmr_clear: assert property (p_tmr_clear) else $error("read did not clear timer");
   property p_low_seen; !lin_rx_i [*5] |-> lin_low_o; endproperty
   a_low_seen: assert property (p_low_seen) else $error("low bus not seen");
   property p_en_off; en_off |=> !irq_o; endproperty
   a_en_off: assert property (p_en_off) else $error("irq with nothing enabled");
   property p_irq_sta; irq_o && rd_sta |=> (rd_data_o[7:0] & `FLAG_MASK) != 8'h00; endproperty
   a_irq_sta: assert property (p_irq_sta) else $error("irq without status");
   // flags only arise while the bus is low, so a high idle bus keeps irq
   property p_quiet; (lin_rx_i && !wr_i) [*6] |=> $stable(irq_o); endproperty
   a_quiet: assert property (p_quiet) else $error("irq moved on idle bus");
   c_irq: cover property ($rose(irq_o));
   c_tmr2: cover property (rd_tmr ##1 rd_tmr);
   c_low: cover property ($fell(lin_low_o));
endmodule // lin_brk_checker

bind lin_break_detector lin_brk_checker chk (.sys_clk_i, .reset_n_i, .addr_i, .wr_data_i, .wr_i,
                                             .rd_i, .rd_data_o, .lin_rx_i, .irq_o, .lin_low_o);

//--- tb/lin_master_model.sv
// LIN master stand-in driving the bus level
// assumes the bench calls its tasks from the clocked main sequence
`timescale 1ns/10ps
module lin_master_model (
   // clock
   input wire clk_i,
   // bus level, recessive high by pull-up
   output reg bus_o
);
   // recessive until a frame starts
   initial bus_o = 1'b1;
   // dominant break; the bench holds it far past 13 bit times
   task drive_low;
      @(posedge clk_i);
      bus_o <= 1'b0;
   endtask
   // back to recessive, ends the break
   task let_go;
      @(posedge clk_i);
      bus_o <= 1'b1;
   endtask
endmodule // lin_master_model

//--- tb/tb.sv
// self-checking bench for the break detector
// assumes the master model on the bus and the checker bound in
`timescale 1ns/10ps
`include "lin_brk_defs.vh"
module tb;
   reg         sys_clk_i   = 1'b0;
   reg         reset_n_i   = 1'b0;
   reg  [31:0] addr_i      = 32'h0000_0000;
   reg  [31:0] wr_data_i   = 32'h0000_0000;
   reg         wr_i        = 1'b0;
   reg         rd_i        = 1'b0;
   wire [31:0] rd_data_o;
   wire        lin_rx_i;
   wire        irq_o;
   wire        lin_low_o;
   integer     num_errors  = 0;
   integer     check_count = 0;
   reg  [31:0] got;
   reg  [31:0] got2;
   // 50 MHz system clock
   always #10 sys_clk_i = ~sys_clk_i;
   lin_break_detector uut (.sys_clk_i, .reset_n_i, .addr_i, .wr_data_i, .wr_i,
                           .rd_i, .rd_data_o, .lin_rx_i, .irq_o, .lin_low_o);
   lin_master_model m (.clk_i(sys_clk_i), .bus_o(lin_rx_i));
   // one verdict point for normal end and timeouts
   task summarize;
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task ok(input c, input [8*12:1] what);
      check_count = check_count + 1;
      if (c !== 1'b1) begin
         $display("[ERR] %0t %0s", $time, what);
         num_errors = num_errors + 1;
      end
   endtask
   task idle(input integer n);
      repeat (n) @(posedge sys_clk_i);
   endtask
   task wr(input [31:0] a, input [31:0] d);
      @(posedge sys_clk_i);
      wr_i      <= 1'b1;
      addr_i    <= a;
      wr_data_i <= d;
      @(posedge sys_clk_i);
      wr_i <= 1'b0;
   endtask
   task rd(input [31:0] a);
      @(posedge sys_clk_i);
      rd_i   <= 1'b1;
      addr_i <= a;
      @(posedge sys_clk_i);
      rd_i <= 1'b0;
      #1 got = rd_data_o;
   endtask
   // two timer reads with no gap; got2 follows the clearing read
   task rd_twice;
      @(posedge sys_clk_i);
      rd_i   <= 1'b1;
      addr_i <= `ADDR_BRK_TIMER;
      @(posedge sys_clk_i);
      #1 got = rd_data_o;
      @(posedge sys_clk_i);
      rd_i <= 1'b0;
      #1 got2 = rd_data_o;
   endtask
   // bounded wait; a miss ends the run
   task wait_irq(input integer n);
      integer i;
      i = 0;
      while (irq_o !== 1'b1 && i < n) begin
         @(posedge sys_clk_i);
         i = i + 1;
      end
      ok(irq_o === 1'b1, "irq late");
      if (irq_o !== 1'b1) summarize;
   endtask
   task t_reset_vals;
      rd(`ADDR_BRK_TIMER);
      ok(got === 32'h0000_0000, "timer rst");
      rd(`ADDR_IRQ_CLEAR);
      ok(got === 32'h0000_0000, "clear reads");
      rd(32'hffff_07f0);
      ok(got === 32'h0000_0000, "unmapped");
      rd(`ADDR_CONTROL);
      ok(got === 32'h0000_0001, "lin mode");
   endtask
   // default compare of 71 ticks, then rewrite while the bus stays low
   task t_default_break;
      wr(`ADDR_IRQ_ENABLE, 32'h0000_0013);
      m.drive_low;
      idle(26000);
      ok(irq_o === 1'b0, "early break");
      wait_irq(2500);
      rd(`ADDR_STATUS);
      ok(got === 32'h0000_0001, "break flag");
      wr(`ADDR_BRK_TIMER, 32'h0000_0003);
      idle(800);
      rd_twice;
      ok(got >= 32'h0000_0049, "count lost");
      ok(got2 <= 32'h0000_0001, "no clear");
      wr(`ADDR_IRQ_CLEAR, 32'h0000_0013);
      // timer passes 3 again in this pulse: no second flag
      idle(1600);
      ok(irq_o === 1'b0, "refired");
      rd(`ADDR_STATUS);
      ok(got === 32'h0000_0000, "flag again");
      m.let_go;
      idle(10);
   endtask
   task t_rearm;
      m.drive_low;
      wait_irq(2000);
      m.let_go;
      wr(`ADDR_IRQ_ENABLE, 32'h0000_0000);
      idle(1);
      ok(irq_o === 1'b0, "irq masked");
      rd(`ADDR_STATUS);
      ok(got === 32'h0000_0001, "not sticky");
      wr(`ADDR_IRQ_CLEAR, 32'h0000_0013);
      rd(`ADDR_STATUS);
      ok(got === 32'h0000_0000, "not cleared");
   endtask
   // five short low pulses, falls 100 + hi + 1 clocks apart
   task pulses(input integer hi);
      repeat (5) begin
         m.drive_low;
         idle(99);
         m.let_go;
         idle(hi);
      end
   endtask
   // armed by the break of t_rearm: four 200-clock gaps are 80 ticks at 5 MHz
   task t_sync;
      pulses(99);
      rd(`ADDR_SYNC_TIMER);
      got2 = got;
      ok(got >= 32'h0000_004f && got <= 32'h0000_0051, "sync count");
      rd(`ADDR_STATUS);
      ok(got === 32'h0000_0002, "sync done");
      // no break before these pulses: the held count must not move
      pulses(199);
      rd(`ADDR_SYNC_TIMER);
      ok(got === got2, "sync no brk");
      wr(`ADDR_IRQ_CLEAR, 32'h0000_0013);
   endtask
   // with LIN mode off the timer must not move
   task t_lin_off;
      wr(`ADDR_CONTROL, 32'h0000_0000);
      rd(`ADDR_BRK_TIMER);
      m.drive_low;
      idle(2000);
      rd(`ADDR_BRK_TIMER);
      ok(got === 32'h0000_0000, "counted off");
      m.let_go;
      wr(`ADDR_CONTROL, 32'h0000_0001);
   endtask
   initial begin
      repeat (16) @(posedge sys_clk_i);
      reset_n_i <= 1'b1;
      t_reset_vals;
      t_default_break;
      t_rearm;
      t_sync;
      t_lin_off;
      summarize;
   end
endmodule // tb
